// *** verilog/tq_map.vh ***
// Purpose: Offsets, field positions, reset values and codes of the alert qualifier
// Assumes: Included by every tq_ design file except the hottest-channel finder
// Notes:   Definitions only
`ifndef TQ_MAP_VH
`define TQ_MAP_VH

// ============
// Register map
`define TQ_CONSEC_ADDR      8'h22
`define TQ_HOT_CFG_ADDR     8'h23
`define TQ_HOT_TEMP_ADDR    8'h24
`define TQ_HOT_STAT_ADDR    8'h25
`define TQ_STATUS_ADDR      8'h26
`define TQ_HIGH_FLAG_ADDR   8'h27
`define TQ_LOW_FLAG_ADDR    8'h28
`define TQ_FAULT_FLAG_ADDR  8'h29

// ============
// Consecutive count register fields
`define TQ_EVT_LSB          0
`define TQ_EVT_MSB          2
`define TQ_OVT_LSB          4
`define TQ_OVT_MSB          6
`define TQ_CNT_ONE          3'h0
`define TQ_CNT_TWO          3'h1
`define TQ_CNT_THREE        3'h3
`define TQ_CNT_FOUR         3'h7
`define TQ_CONSEC_RESET     8'h70

// ============
// Hottest config fields and fault result
`define TQ_HOT_TRACK_BIT    7
`define TQ_HOT_PIN_MASK_BIT 6
`define TQ_FAULT_RESULT     8'h00

`endif

// *** verilog/tq_count_decode.v ***
// Purpose: Decode of a 3-bit consecutive count setting
// Assumes: Setting may be unvalidated write data; the register write path checks valid_out
// Notes:   Invalid codes also reported through valid_out
`timescale 1ns/1ns
`include "tq_map.vh"

module tq_count_decode (
    input  wire [2:0] setting_in,
    output reg  [2:0] count_out,
    output reg        valid_out
);

    always @* begin
        valid_out = 1'b1;
        case (setting_in)
            `TQ_CNT_ONE:   count_out = 3'h1;
            `TQ_CNT_TWO:   count_out = 3'h2;
            `TQ_CNT_THREE: count_out = 3'h3;
            `TQ_CNT_FOUR:  count_out = 3'h4;
            default: begin
                count_out = 3'h1;
                valid_out = 1'b0;
            end
        endcase
    end

endmodule // tq_count_decode

// *** verilog/tq_hottest.v ***
// Purpose: Finds the hottest of the selected channels
// Assumes: Combinational; results are registered by the parent
// Notes:   Ties flag every selected channel at the maximum
`timescale 1ns/1ns

module tq_hottest #(
    parameter NCH = 4
) (
    input  wire [NCH*8-1:0] temp_in,
    input  wire [NCH-1:0]   select_in,
    output reg  [7:0]       max_out,
    output reg  [NCH-1:0]   hot_out,
    output reg              any_out
);

    integer i;

    always @* begin
        max_out = 8'h00;
        any_out = 1'b0;
        hot_out = {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1) begin
            if (select_in[i] && (!any_out || temp_in[i*8 +: 8] > max_out)) begin
                max_out = temp_in[i*8 +: 8];
            end
            if (select_in[i]) begin
                any_out = 1'b1;
            end
        end
        for (i = 0; i < NCH; i = i + 1) begin
            hot_out[i] = select_in[i] && (temp_in[i*8 +: 8] == max_out);
        end
    end

endmodule // tq_hottest

// *** verilog/tq_alert_qualifier.v ***
// Purpose: Consecutive-measurement qualifier for event and over-temperature pins
// Assumes: Measurement engine gives one MEAS_VALID_IN pulse per channel result,
//          and CYCLE_END_IN after the last channel of a measurement cycle
// Notes:   Pins are open drain, active low; output enable high pulls low
`timescale 1ns/1ns
`include "tq_map.vh"

// Overview of operation
// - Each channel keeps separate event-pin and over-temperature-pin consecutive counters
// - Interrupt mode: event counter counts high, low or fault results; clears on a clean result
// - Interrupt mode: at count set status and flags, assert pin, clear counter
// - Comparator mode: event counter counts only results above the high limit
// - Comparator mode: counter holds after firing until below high minus hysteresis
// - Comparator mode: low and fault set status directly, never the pin
// - Disabled channels never count nor drive either pin
// - Order is limit, counter, status, mask, then pin
// - When one counter fires, other counters hold until their own measurement
// - Over-temperature counter counts above limit; clears below unless pin asserted
// - After the programmed count above limit, over-temperature pin goes low
// - Asserted over-temperature counter clears only below limit minus hysteresis
// - Count codes 000,001,011,111 mean one, two, three, four measurements
// - Reset gives event count one and over-temperature count four
// - Writes with an undefined count code are ignored entirely
// - At cycle end the hottest selected temperature and its status are stored
// - Every selected channel tied at the hottest value gets its status bit
// - With tracking enabled, a hottest-channel change raises an event
// - A diode fault forces the result to 00h and counts as a fault
module tq_alert_qualifier #(
    parameter NCH = 4
) (
    input  wire             CLK_IN,
    input  wire             RESET_IN,
    input  wire             MEAS_VALID_IN,
    input  wire [1:0]       MEAS_CHAN_IN,
    input  wire [7:0]       MEAS_TEMP_IN,
    input  wire             MEAS_FAULT_IN,
    input  wire             CYCLE_END_IN,
    input  wire [7:0]       HIGH_LIMIT_IN,
    input  wire [7:0]       LOW_LIMIT_IN,
    input  wire [7:0]       OVT_LIMIT_IN,
    input  wire [7:0]       HYST_IN,
    input  wire             COMPARATOR_MODE_IN,
    input  wire [NCH-1:0]   CHAN_ENABLE_IN,
    input  wire [NCH-1:0]   EVENT_MASK_IN,
    input  wire [NCH-1:0]   OVT_MASK_IN,
    input  wire             REG_WR_IN,
    input  wire             REG_RD_IN,
    input  wire [7:0]       REG_ADDR_IN,
    input  wire [7:0]       REG_WDATA_IN,
    output reg  [7:0]       REG_RDATA_OUT,
    output reg  [7:0]       RESULT_OUT,
    output reg              EVENT_N_OUT,
    output reg              EVENT_N_OE_OUT,
    output reg              OVT_N_OUT,
    output reg              OVT_N_OE_OUT
);

    // ============
    // Registers
    reg  [7:0]       consec_q;
    reg  [7:0]       hot_cfg_q;
    reg  [7:0]       hot_temp_q;
    reg  [NCH-1:0]   hot_stat_q;
    reg              hot_valid_q;
    reg              hot_event_q;

    reg  [NCH-1:0]   status_q;
    reg  [NCH-1:0]   high_flag_q;
    reg  [NCH-1:0]   low_flag_q;
    reg  [NCH-1:0]   fault_flag_q;
    reg  [2:0]       evt_cnt_q [0:NCH-1];
    reg  [2:0]       ovt_cnt_q [0:NCH-1];
    reg  [NCH-1:0]   evt_pin_q;
    reg  [NCH-1:0]   ovt_pin_q;
    reg  [7:0]       temp_q [0:NCH-1];

    wire [2:0]       evt_need;
    wire [2:0]       ovt_need;
    wire             evt_ok;
    wire             ovt_ok;
    wire [2:0]       wr_evt_need;
    wire [2:0]       wr_ovt_need;
    wire             wr_evt_ok;
    wire             wr_ovt_ok;
    wire [NCH*8-1:0] temp_flat;
    wire [7:0]       hot_max;
    wire [NCH-1:0]   hot_now;
    wire             hot_any;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_flat
            assign temp_flat[g*8 +: 8] = temp_q[g];
        end
    endgenerate

    // ============
    // Count decode
    tq_count_decode u_evt_dec (
        .setting_in (consec_q[`TQ_EVT_MSB:`TQ_EVT_LSB]),
        .count_out  (evt_need),
        .valid_out  (evt_ok)
    );

    tq_count_decode u_ovt_dec (
        .setting_in (consec_q[`TQ_OVT_MSB:`TQ_OVT_LSB]),
        .count_out  (ovt_need),
        .valid_out  (ovt_ok)
    );

    tq_count_decode u_wr_evt_dec (
        .setting_in (REG_WDATA_IN[`TQ_EVT_MSB:`TQ_EVT_LSB]),
        .count_out  (wr_evt_need),
        .valid_out  (wr_evt_ok)
    );

    tq_count_decode u_wr_ovt_dec (
        .setting_in (REG_WDATA_IN[`TQ_OVT_MSB:`TQ_OVT_LSB]),
        .count_out  (wr_ovt_need),
        .valid_out  (wr_ovt_ok)
    );

    tq_hottest #(.NCH(NCH)) u_hot (
        .temp_in   (temp_flat),
        .select_in (hot_cfg_q[NCH-1:0] & CHAN_ENABLE_IN),
        .max_out   (hot_max),
        .hot_out   (hot_now),
        .any_out   (hot_any)
    );

    // ============
    // Per-measurement classification
    // Saturating subtract keeps a small limit from wrapping to a huge threshold
    function [7:0] sat_sub;
        input [7:0] a;
        input [7:0] b;
        sat_sub = (a > b) ? a - b : 8'h00;
    endfunction

    wire [7:0] res_temp  = MEAS_FAULT_IN ? `TQ_FAULT_RESULT : MEAS_TEMP_IN;
    wire       is_fault  = MEAS_FAULT_IN;

    wire       is_high   = !is_fault && (MEAS_TEMP_IN > HIGH_LIMIT_IN);
    // Fault result is not checked against the low limit
    wire       is_low    = !is_fault && (MEAS_TEMP_IN < LOW_LIMIT_IN);
    wire       is_ovt    = !is_fault && (MEAS_TEMP_IN > OVT_LIMIT_IN);

    wire [7:0] high_rel  = sat_sub(HIGH_LIMIT_IN, HYST_IN);
    wire [7:0] ovt_rel   = sat_sub(OVT_LIMIT_IN, HYST_IN);
    wire       below_hr  = is_fault || (MEAS_TEMP_IN < high_rel);
    wire       below_or  = is_fault || (MEAS_TEMP_IN < ovt_rel);

    wire       chan_on   = CHAN_ENABLE_IN[MEAS_CHAN_IN];
    wire       take      = MEAS_VALID_IN && chan_on;
    wire [2:0] ec        = evt_cnt_q[MEAS_CHAN_IN];
    wire [2:0] oc        = ovt_cnt_q[MEAS_CHAN_IN];

    // ============
    // Counters, status and per-channel pin requests
    integer i;

    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            for (i = 0; i < NCH; i = i + 1) begin
                evt_cnt_q[i] <= 3'h0;
                ovt_cnt_q[i] <= 3'h0;
                temp_q[i]    <= 8'h00;
            end

            status_q     <= {NCH{1'b0}};
            high_flag_q  <= {NCH{1'b0}};
            low_flag_q   <= {NCH{1'b0}};
            fault_flag_q <= {NCH{1'b0}};
            evt_pin_q    <= {NCH{1'b0}};
            ovt_pin_q    <= {NCH{1'b0}};
            RESULT_OUT   <= 8'h00;
        end else begin
            // Disabled channels drop their pin requests
            evt_pin_q <= evt_pin_q & CHAN_ENABLE_IN;
            ovt_pin_q <= ovt_pin_q & CHAN_ENABLE_IN;

            if (REG_RD_IN && REG_ADDR_IN == `TQ_STATUS_ADDR) begin
                status_q  <= {NCH{1'b0}};
                evt_pin_q <= COMPARATOR_MODE_IN ? evt_pin_q & CHAN_ENABLE_IN : {NCH{1'b0}};
            end

            if (REG_RD_IN && REG_ADDR_IN == `TQ_HIGH_FLAG_ADDR) begin
                high_flag_q <= {NCH{1'b0}};
            end

            if (REG_RD_IN && REG_ADDR_IN == `TQ_LOW_FLAG_ADDR) begin
                low_flag_q <= {NCH{1'b0}};
            end

            if (REG_RD_IN && REG_ADDR_IN == `TQ_FAULT_FLAG_ADDR) begin
                fault_flag_q <= {NCH{1'b0}};
            end

            if (MEAS_VALID_IN) begin
                RESULT_OUT             <= res_temp;
                temp_q[MEAS_CHAN_IN]   <= res_temp;
            end

            // Only the measured channel moves; others hold
            if (take) begin
                if (!COMPARATOR_MODE_IN) begin
                    if (is_high || is_low || is_fault) begin
                        if (ec + 3'h1 >= evt_need) begin
                            // Set wins over a same-cycle read clear
                            status_q[MEAS_CHAN_IN]     <= 1'b1;
                            high_flag_q[MEAS_CHAN_IN]  <= high_flag_q[MEAS_CHAN_IN] | is_high;
                            low_flag_q[MEAS_CHAN_IN]   <= low_flag_q[MEAS_CHAN_IN] | is_low;
                            fault_flag_q[MEAS_CHAN_IN] <= fault_flag_q[MEAS_CHAN_IN] | is_fault;
                            evt_pin_q[MEAS_CHAN_IN]    <= 1'b1;
                            evt_cnt_q[MEAS_CHAN_IN]    <= 3'h0;
                        end else begin
                            evt_cnt_q[MEAS_CHAN_IN] <= ec + 3'h1;
                        end
                    end else begin
                        evt_cnt_q[MEAS_CHAN_IN] <= 3'h0;
                    end
                end else begin
                    if (is_high) begin
                        if (ec + 3'h1 >= evt_need) begin
                            status_q[MEAS_CHAN_IN]    <= 1'b1;
                            high_flag_q[MEAS_CHAN_IN] <= 1'b1;
                            evt_pin_q[MEAS_CHAN_IN]   <= 1'b1;
                            evt_cnt_q[MEAS_CHAN_IN]   <= evt_need;
                        end else begin
                            evt_cnt_q[MEAS_CHAN_IN] <= ec + 3'h1;
                        end
                    end else if (!evt_pin_q[MEAS_CHAN_IN] || below_hr) begin
                        evt_cnt_q[MEAS_CHAN_IN] <= 3'h0;
                        evt_pin_q[MEAS_CHAN_IN] <= 1'b0;
                    end

                    if (is_low || is_fault) begin
                        status_q[MEAS_CHAN_IN]     <= 1'b1;
                        low_flag_q[MEAS_CHAN_IN]   <= low_flag_q[MEAS_CHAN_IN] | is_low;
                        fault_flag_q[MEAS_CHAN_IN] <= fault_flag_q[MEAS_CHAN_IN] | is_fault;
                    end
                end

                if (is_ovt) begin
                    if (oc + 3'h1 >= ovt_need) begin
                        ovt_cnt_q[MEAS_CHAN_IN] <= ovt_need;
                        ovt_pin_q[MEAS_CHAN_IN] <= 1'b1;
                    end else begin
                        ovt_cnt_q[MEAS_CHAN_IN] <= oc + 3'h1;
                    end
                end else if (!ovt_pin_q[MEAS_CHAN_IN] || below_or) begin
                    ovt_cnt_q[MEAS_CHAN_IN] <= 3'h0;
                    ovt_pin_q[MEAS_CHAN_IN] <= 1'b0;
                end
            end
        end
    end

    // ============
    // Hottest tracking
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            hot_temp_q  <= 8'h00;
            hot_stat_q  <= {NCH{1'b0}};
            hot_valid_q <= 1'b0;
            hot_event_q <= 1'b0;
        end else begin
            if (REG_RD_IN && REG_ADDR_IN == `TQ_HOT_STAT_ADDR) begin
                hot_event_q <= 1'b0;
            end

            if (CYCLE_END_IN && hot_any) begin
                hot_temp_q  <= hot_max;
                hot_stat_q  <= hot_now;
                hot_valid_q <= 1'b1;
                // First cycle after reset has nothing to compare against
                if (hot_cfg_q[`TQ_HOT_TRACK_BIT] && hot_valid_q && hot_now != hot_stat_q) begin
                    hot_event_q <= 1'b1;
                end
            end
        end
    end

    // ============
    // Register port
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            consec_q      <= `TQ_CONSEC_RESET;
            hot_cfg_q     <= 8'h00;
            REG_RDATA_OUT <= 8'h00;
        end else begin
            if (REG_WR_IN && REG_ADDR_IN == `TQ_CONSEC_ADDR && wr_evt_ok && wr_ovt_ok) begin
                consec_q <= {1'b0, REG_WDATA_IN[`TQ_OVT_MSB:`TQ_OVT_LSB], 1'b0,
                             REG_WDATA_IN[`TQ_EVT_MSB:`TQ_EVT_LSB]};
            end

            if (REG_WR_IN && REG_ADDR_IN == `TQ_HOT_CFG_ADDR) begin
                hot_cfg_q <= REG_WDATA_IN;
            end

            case (REG_ADDR_IN)
                `TQ_CONSEC_ADDR:     REG_RDATA_OUT <= consec_q;
                `TQ_HOT_CFG_ADDR:    REG_RDATA_OUT <= hot_cfg_q;
                `TQ_HOT_TEMP_ADDR:   REG_RDATA_OUT <= hot_temp_q;
                `TQ_HOT_STAT_ADDR:   REG_RDATA_OUT <= {hot_event_q, {(7-NCH){1'b0}}, hot_stat_q};
                `TQ_STATUS_ADDR:     REG_RDATA_OUT <= {{(8-NCH){1'b0}}, status_q};
                `TQ_HIGH_FLAG_ADDR:  REG_RDATA_OUT <= {{(8-NCH){1'b0}}, high_flag_q};
                `TQ_LOW_FLAG_ADDR:   REG_RDATA_OUT <= {{(8-NCH){1'b0}}, low_flag_q};
                `TQ_FAULT_FLAG_ADDR: REG_RDATA_OUT <= {{(8-NCH){1'b0}}, fault_flag_q};
                default:             REG_RDATA_OUT <= 8'h00;
            endcase
        end
    end

    // ============
    // Mask stage and pins
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            EVENT_N_OUT    <= 1'b0;
            EVENT_N_OE_OUT <= 1'b0;
            OVT_N_OUT      <= 1'b0;
            OVT_N_OE_OUT   <= 1'b0;
        end else begin
            EVENT_N_OUT    <= 1'b0;
            OVT_N_OUT      <= 1'b0;
            EVENT_N_OE_OUT <= |(evt_pin_q & ~EVENT_MASK_IN & CHAN_ENABLE_IN)
                              | (hot_event_q && !hot_cfg_q[`TQ_HOT_PIN_MASK_BIT]);
            OVT_N_OE_OUT   <= |(ovt_pin_q & ~OVT_MASK_IN & CHAN_ENABLE_IN);
        end
    end

endmodule // tq_alert_qualifier

// *** dv/tq_alert_qualifier_assertions.sv ***
// Purpose: Port-level assertions for the alert qualifier
// Assumes: Masks and enables held steady while a pin is asserted
// Notes:   Pin timing is counter edge plus one, so causes sit two samples back
`timescale 1ns/1ns
module tq_alert_qualifier_chk #(
    parameter NCH = 4
) (
    input wire logic           CLK_IN,
    input wire logic           RESET_IN,
    input wire logic           MEAS_VALID_IN,
    input wire logic [1:0]     MEAS_CHAN_IN,
    input wire logic [7:0]     MEAS_TEMP_IN,
    input wire logic           MEAS_FAULT_IN,
    input wire logic           CYCLE_END_IN,
    input wire logic [7:0]     HIGH_LIMIT_IN,
    input wire logic [7:0]     OVT_LIMIT_IN,
    input wire logic [7:0]     HYST_IN,
    input wire logic           COMPARATOR_MODE_IN,
    input wire logic [NCH-1:0] CHAN_ENABLE_IN,
    input wire logic           REG_RD_IN,
    input wire logic [7:0]     REG_ADDR_IN,
    input wire logic [7:0]     RESULT_OUT,
    input wire logic           EVENT_N_OUT,
    input wire logic           EVENT_N_OE_OUT,
    input wire logic           OVT_N_OUT,
    input wire logic           OVT_N_OE_OUT
);
    // ======
    // Properties
    default clocking dc @(posedge CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    property p_fault_zero; MEAS_VALID_IN && MEAS_FAULT_IN |=> RESULT_OUT == 8'h00; endproperty
    a_fault_zero: assert property (p_fault_zero)
        else $error("fault result not zero");
    property p_pin_levels; !EVENT_N_OUT && !OVT_N_OUT; endproperty
    a_pin_levels: assert property (p_pin_levels)
        else $error("pin data not low");
    property p_ovt_rise; $rose(OVT_N_OE_OUT) |-> $past(MEAS_VALID_IN, 2) &&
        !$past(MEAS_FAULT_IN, 2) && $past(MEAS_TEMP_IN, 2) > $past(OVT_LIMIT_IN, 2); endproperty
    a_ovt_rise: assert property (p_ovt_rise)
        else $error("overtemp pin rose without cause");
    property p_ovt_enabled; $rose(OVT_N_OE_OUT) |-> $past(CHAN_ENABLE_IN[MEAS_CHAN_IN], 2);
    endproperty
    a_ovt_enabled: assert property (p_ovt_enabled)
        else $error("overtemp pin from disabled channel");
    property p_evt_rise; $rose(EVENT_N_OE_OUT) |-> $past(MEAS_VALID_IN, 2) ||
        $past(CYCLE_END_IN, 1) || $past(CYCLE_END_IN, 2) || $past(CYCLE_END_IN, 3); endproperty
    a_evt_rise: assert property (p_evt_rise)
        else $error("event pin rose without cause");
    property p_cmp_rise; $rose(EVENT_N_OE_OUT) && COMPARATOR_MODE_IN |-> $past(MEAS_VALID_IN, 2)
        && !$past(MEAS_FAULT_IN, 2) && $past(MEAS_TEMP_IN, 2) > $past(HIGH_LIMIT_IN, 2);
    endproperty
    a_cmp_rise: assert property (p_cmp_rise)
        else $error("comparator pin rose without high result");
    property p_int_clear; EVENT_N_OE_OUT && REG_RD_IN && REG_ADDR_IN == 8'h26 &&
        !COMPARATOR_MODE_IN |-> ##[1:3] !EVENT_N_OE_OUT; endproperty
    a_int_clear: assert property (p_int_clear)
        else $error("status read did not release event pin");
    property p_ovt_fall; $fell(OVT_N_OE_OUT) |-> $past(MEAS_VALID_IN, 2) && {1'b0,
        $past(MEAS_FAULT_IN, 2) ? 8'h00 : $past(MEAS_TEMP_IN, 2)} + $past(HYST_IN, 2)
        < $past(OVT_LIMIT_IN, 2); endproperty
    a_ovt_fall: assert property (p_ovt_fall)
        else $error("overtemp pin released above hysteresis");
    property p_cmp_fall; $fell(EVENT_N_OE_OUT) && COMPARATOR_MODE_IN |-> $past(MEAS_VALID_IN, 2)
        && {1'b0, $past(MEAS_TEMP_IN, 2)} + $past(HYST_IN, 2) < $past(HIGH_LIMIT_IN, 2);
    endproperty
    a_cmp_fall: assert property (p_cmp_fall)
        else $error("comparator pin released above hysteresis");
endmodule // tq_alert_qualifier_chk

bind tq_alert_qualifier tq_alert_qualifier_chk #(.NCH(NCH)) u_tq_alert_qualifier_chk (
    .CLK_IN, .RESET_IN, .MEAS_VALID_IN, .MEAS_CHAN_IN, .MEAS_TEMP_IN, .MEAS_FAULT_IN,
    .CYCLE_END_IN, .HIGH_LIMIT_IN, .OVT_LIMIT_IN, .HYST_IN, .COMPARATOR_MODE_IN,
    .CHAN_ENABLE_IN, .REG_RD_IN, .REG_ADDR_IN, .RESULT_OUT, .EVENT_N_OUT, .EVENT_N_OE_OUT,
    .OVT_N_OUT, .OVT_N_OE_OUT);

// *** dv/tq_meas_model.sv ***
// Purpose: Measurement engine stand-in feeding channel results
// Assumes: Called just after a rising edge
// Notes:   Data lines show the inverted last value between results
`timescale 1ns/1ns
module tq_meas_model (
    input  wire logic       clk_in,
    output logic            valid_out = 1'b0,
    output logic [1:0]      chan_out = 2'h0,
    output logic [7:0]      temp_out = 8'h00,
    output logic            fault_out = 1'b0,
    output logic            cycle_end_out = 1'b0
);
    // ======
    // One result per call, one-cycle strobe
    task measure(input logic [1:0] ch, input logic [7:0] t, input logic f);
        @(posedge clk_in);
        #5;
        valid_out = 1'b1;
        chan_out = ch;
        temp_out = t;
        fault_out = f;
        @(posedge clk_in);
        #5;
        valid_out = 1'b0;
        chan_out = ~ch;
        temp_out = ~t;
        fault_out = ~f;
    endtask

    task cycle_end();
        @(posedge clk_in);
        #5;
        cycle_end_out = 1'b1;
        @(posedge clk_in);
        #5;
        cycle_end_out = 1'b0;
    endtask
endmodule // tq_meas_model

// *** dv/test_tq_alert_qualifier.sv ***
// Purpose: Self-checking bench for the alert qualifier
// Assumes: Status at 26h reads nonzero while any status bit is set
// Notes:   Integer reference model; pins checked after every result
`timescale 1ns/1ns
module test_tq_alert_qualifier;
    // ======
    // Stimulus and reference state
    logic       clk = 1'b0, rst = 1'b1, cmp = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdat = 8'h00, high = 8'h60, low = 8'h20, ovt = 8'hC0;
    logic [7:0] hyst = 8'h08;
    logic [3:0] en = 4'hF, emask = 4'h0, omask = 4'h0, ef, of;
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic [7:0] seq [10] = '{8'h00, 8'h10, 8'h61, 8'h61, 8'h5D, 8'h57, 8'h81, 8'h81, 8'h79, 8'h77};
    wire        mv, mf, cyc, eo, eoe, oo, ooe;
    wire  [1:0] mc;
    wire  [7:0] mt, rdat, res;
    int         fail_count = 0, n_checks = 0, ne, no, ec[4], oc[4];
    bit         st, epin;

    always #50 clk = ~clk;

    tq_meas_model u_tq_meas_model (.clk_in(clk), .valid_out(mv), .chan_out(mc), .temp_out(mt),
        .fault_out(mf), .cycle_end_out(cyc));

    tq_alert_qualifier #(.NCH(4)) u_tq_alert_qualifier (
        .CLK_IN(clk), .RESET_IN(rst), .MEAS_VALID_IN(mv), .MEAS_CHAN_IN(mc), .MEAS_TEMP_IN(mt),
        .MEAS_FAULT_IN(mf), .CYCLE_END_IN(cyc), .HIGH_LIMIT_IN(high), .LOW_LIMIT_IN(low),
        .OVT_LIMIT_IN(ovt), .HYST_IN(hyst), .COMPARATOR_MODE_IN(cmp), .CHAN_ENABLE_IN(en),
        .EVENT_MASK_IN(emask), .OVT_MASK_IN(omask), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdat), .REG_RDATA_OUT(rdat), .RESULT_OUT(res),
        .EVENT_N_OUT(eo), .EVENT_N_OE_OUT(eoe), .OVT_N_OUT(oo), .OVT_N_OE_OUT(ooe));

    // ======
    // Shared tasks
    task tick(input int n = 1);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task end_sim();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task do_reset();
        rst = 1'b1;
        cmp = 1'b0;
        en = 4'hF;
        emask = 4'h0;
        tick(16);
        rst = 1'b0;
        {ne, no, st, epin, ef, of} = {32'd1, 32'd4, 10'h000};
        ec = '{default: 0};
        oc = '{default: 0};
    endtask

    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdat = d;
        wr = 1'b1;
        tick();
        wr = 1'b0;
        tick();
    endtask

    task rd_chk(input logic [7:0] a, input logic [7:0] exp, input bit any = 0);
        addr = a;
        rd = 1'b1;
        tick();
        chk(any ? {7'h00, rdat != 8'h00} : rdat, exp);
        rd = 1'b0;
        tick();
    endtask

    task cfg(input logic [2:0] e, input logic [2:0] o);
        reg_wr(8'h22, {1'b0, o, 1'b0, e});
        ne = (e == 3'h7) ? 4 : (e == 3'h3) ? 3 : int'(e) + 1;
        no = (o == 3'h7) ? 4 : (o == 3'h3) ? 3 : int'(o) + 1;
    endtask

    // Reference model
    task mdl(input int ch, input int t, input bit f);
        int tv;
        bit hi;
        bit lo;
        tv = f ? 0 : t;
        hi = !f && t > high;
        lo = !f && t < low;
        if (en[ch]) begin
            if (cmp) begin
                if (lo || f) st = 1'b1;
                if (ef[ch] && tv + hyst < high) begin
                    ef[ch] = 1'b0;
                    ec[ch] = 0;
                end else if (!ef[ch] && hi) begin
                    ec[ch]++;
                    ef[ch] = ec[ch] == ne;
                    st = st | ef[ch];
                end else if (!ef[ch]) begin
                    ec[ch] = 0;
                end
            end else if (hi || lo || f) begin
                ec[ch]++;
                if (ec[ch] == ne) begin
                    ec[ch] = 0;
                    st = 1'b1;
                    epin = epin | !emask[ch];
                end
            end else begin
                ec[ch] = 0;
            end
            if (of[ch] && tv + hyst < ovt) begin
                of[ch] = 1'b0;
                oc[ch] = 0;
            end else if (!of[ch] && tv > ovt) begin
                oc[ch]++;
                of[ch] = oc[ch] == no;
            end else if (!of[ch]) begin
                oc[ch] = 0;
            end
        end
    endtask

    task pins();
        chk({6'h00, ooe, eoe}, {6'h00, |(of & ~omask), cmp ? |(ef & ~emask) : epin});
    endtask

    task meas(input int ch, input int t, input bit f);
        u_tq_meas_model.measure(ch[1:0], t[7:0], f);
        mdl(ch, t, f);
        tick();
        chk(res, f ? 8'h00 : t[7:0]);
        pins();
    endtask

    task stat_clear();
        rd_chk(8'h26, {7'h00, st}, 1);
        {st, epin} = 2'b00;
        tick(2);
        pins();
    endtask

    // ======
    // Main sequence
    initial begin
        logic [7:0] t, hmax;
        logic [3:0] hmap, pmap;
        int ch;
        ch = $urandom(32'h2e6c);
        do_reset();
        rd_chk(8'h22, 8'h70);
        foreach (codes[i]) begin
            cfg(codes[i], codes[3 - i]);
            rd_chk(8'h22, {1'b0, codes[3 - i], 1'b0, codes[i]});
        end
        reg_wr(8'h22, 8'h25);
        reg_wr(8'h22, 8'h53);
        rd_chk(8'h22, 8'h07);
        reg_wr(8'h22, 8'hB3);
        rd_chk(8'h22, 8'h33);
        $display("register test done");
        foreach (codes[i]) begin
            do_reset();
            cfg(codes[i], 3'h7);
            ch = $urandom % 4;
            en[ch] = i != 2;
            emask[ch] = i == 1;
            for (int k = 1; k < ne; k++) begin
                meas(ch, 8'h61 + $urandom % 32, 0);
                meas(ch ^ 1, 8'h61, 0);
            end
            meas(ch, 8'h40, 0);
            repeat (ne) meas(ch, ($urandom % 3 == 0) ? 8'h10 : 8'h70, $urandom % 3 == 0);
            stat_clear();
        end
        $display("interrupt test done");
        do_reset();
        {cmp, ovt} = {1'b1, 8'h80};
        cfg(3'h1, 3'h1);
        ch = $urandom % 4;
        foreach (seq[i]) begin
            if (i == 2) stat_clear();
            meas(ch, seq[i], i == 0);
        end
        $display("comparator test done");
        do_reset();
        {high, low, pmap} = {8'hFF, 8'h00, 4'h0};
        for (int k = 0; k < 2; k++) begin
            reg_wr(8'h23, k ? 8'h8B : 8'h0B);
            {hmax, hmap} = 12'h000;
            for (int j = 0; j < 4; j++) begin
                t = 8'h40 + $urandom % 4;
                meas(j, t, 0);
                if (j != 2 && t > hmax) hmap = 4'h0;
                if (j != 2 && t >= hmax) hmap[j] = 1'b1;
                if (j != 2 && t > hmax) hmax = t;
            end
            u_tq_meas_model.cycle_end();
            tick(2);
            rd_chk(8'h24, hmax);
            rd_chk(8'h25, {k == 1 && hmap != pmap, 3'h0, hmap});
            pmap = hmap;
        end
        $display("hottest test done");
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule // test_tq_alert_qualifier
